// File: verilog/mbp_pkg.sv
// constants and types shared by the probe register bank and its link controller
package mbp_pkg;
  // link function codes
  localparam logic [7:0]  FN_READ        = 8'h03;
  localparam logic [7:0]  FN_WRITE       = 8'h10;
  localparam logic [7:0]  FN_IDENT       = 8'h2b;
  localparam logic [7:0]  MEI_IDENT      = 8'h0e;
  // register addresses (zero based)
  localparam logic [15:0] RA_HUMIDITY    = 16'h0000;
  localparam logic [15:0] RA_TEMPERATURE = 16'h0002;
  localparam logic [15:0] RA_DEW_POINT   = 16'h0008;
  localparam logic [15:0] RA_FAULT       = 16'h0200;
  localparam logic [15:0] RA_ERROR       = 16'h0203;
  localparam logic [15:0] RA_HASH        = 16'h0205;
  localparam logic [15:0] RA_FILTER      = 16'h0310;
  localparam logic [15:0] RA_SLAVE_ADDR  = 16'h0600;
  localparam logic [15:0] RA_BAUD        = 16'h0601;
  localparam logic [15:0] RA_FRAME       = 16'h0602;
  localparam logic [15:0] RA_DELAY       = 16'h0603;
  localparam logic [15:0] RA_PROTOCOL    = 16'h0604;
  localparam logic [15:0] RA_RESTART     = 16'h0605;
  localparam logic [15:0] RA_TEST_INT    = 16'h1f00;
  localparam logic [15:0] RA_TEST_FLOAT  = 16'h1f01;
  localparam logic [15:0] RA_TEST_TEXT   = 16'h1f03;
  // constant values
  localparam logic [15:0] TEST_INT_VAL   = 16'hcfc7;
  localparam logic [31:0] TEST_FLOAT_VAL = 32'hc2f6e666;
  localparam logic [63:0] TEST_TEXT_VAL  = 64'h2d3132332e343500;
  localparam logic [31:0] QUIET_NAN      = 32'h7fc00000;
  // setting reset values, RTU baud limits and RTU protocol code
  localparam logic [31:0] RST_FILTER     = 32'h3f800000;
  localparam logic [15:0] RST_SLAVE_ADDR = 16'h00f0;
  localparam logic [15:0] RST_BAUD       = 16'h0005;
  localparam logic [15:0] RST_FRAME      = 16'h0001;
  localparam logic [15:0] RST_DELAY      = 16'h0000;
  localparam logic [15:0] RST_PROTOCOL   = 16'h0006;
  localparam logic [15:0] BAUD_MIN_RTU   = 16'h0005;
  localparam logic [15:0] BAUD_MAX_CODE  = 16'h0008;
  localparam logic [15:0] PROTO_RTU      = 16'h0006;
  // identity objects; text values arbitrary, at most seven characters
  localparam logic [7:0]  OBJ_LAST_STD   = 8'h04;
  localparam logic [7:0]  OBJ_FIRST_EXT  = 8'h80;
  localparam logic [7:0]  OBJ_LAST_EXT   = 8'h82;
  // host register byte offsets
  localparam logic [7:0]  HR_CMD         = 8'h00;
  localparam logic [7:0]  HR_ADDR        = 8'h04;
  localparam logic [7:0]  HR_WDATA_LO    = 8'h08;
  localparam logic [7:0]  HR_WDATA_HI    = 8'h0c;
  localparam logic [7:0]  HR_RDATA_LO    = 8'h10;
  localparam logic [7:0]  HR_RDATA_HI    = 8'h14;
  localparam logic [7:0]  HR_STATUS      = 8'h18;
  // timing
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned POWERUP_WAIT_S = 2;
  localparam int unsigned POWERUP_CYCLES = POWERUP_WAIT_S * CLK_HZ;

  typedef enum logic [1:0] {HS_WAIT, HS_IDLE, HS_BUSY} mbp_host_state_type;

  // true where a register starts a 32-bit pair
  function automatic logic mbp_pair_start(input logic [15:0] a);
    return a == RA_HUMIDITY || a == RA_TEMPERATURE || a == RA_DEW_POINT || a == RA_ERROR ||
           a == RA_HASH || a == RA_FILTER || a == RA_TEST_FLOAT;
  endfunction

  // baud code to bits per second, zero for unknown code
  function automatic logic [15:0] mbp_baud_bps(input logic [15:0] c);
    case (c)
      16'h0000: return 16'd300;
      16'h0001: return 16'd600;
      16'h0002: return 16'd1200;
      16'h0003: return 16'd2400;
      16'h0004: return 16'd4800;
      16'h0005: return 16'd9600;
      16'h0006: return 16'd19200;
      16'h0007: return 16'd38400;
      16'h0008: return 16'd57600;
      default:  return 16'h0000;
    endcase
  endfunction
endpackage

// File: verilog/mbp_link_if.sv
// request and answer link between the master and the probe register bank
`timescale 1ns/1ps
interface mbp_link_if;
  logic        req_valid;
  logic [7:0]  req_func;
  logic [7:0]  req_mei;
  logic [15:0] req_addr;
  logic [2:0]  req_count;
  logic [63:0] req_wdata;
  logic [7:0]  req_obj;
  logic        req_stream;
  logic        rsp_valid;
  logic        rsp_exc;
  logic [63:0] rsp_data;
  logic [7:0]  rsp_next_obj;
  logic        rsp_more;
  modport device (input req_valid, req_func, req_mei, req_addr, req_count, req_wdata, req_obj, req_stream,
                  output rsp_valid, rsp_exc, rsp_data, rsp_next_obj, rsp_more);
  modport master (output req_valid, req_func, req_mei, req_addr, req_count, req_wdata, req_obj, req_stream,
                  input rsp_valid, rsp_exc, rsp_data, rsp_next_obj, rsp_more);
endinterface

// File: verilog/mbp_probe_regs.sv
// probe register bank: measurement, status, settings, identity and test registers
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module mbp_probe_regs
  import mbp_pkg::*;
#(
  parameter logic [63:0] OBJ_MAKER    = 64'h6d616b6572000000, // arbitrary
  parameter logic [63:0] OBJ_PART     = 64'h7061727431000000, // arbitrary
  parameter logic [63:0] OBJ_REVISION = 64'h312e300000000000, // arbitrary
  parameter logic [63:0] OBJ_URL      = 64'h75726c0000000000, // arbitrary
  parameter logic [63:0] OBJ_NAME     = 64'h70726f6265000000, // arbitrary
  parameter logic [63:0] OBJ_SERIAL   = 64'h3030303031000000, // arbitrary
  parameter logic [63:0] OBJ_CAL_DATE = 64'h3230303031000000, // arbitrary
  parameter logic [63:0] OBJ_CAL_NOTE = 64'h6c61620000000000  // arbitrary
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  mbp_link_if.device       link,
  input  wire logic [31:0] humidity_i,
  input  wire logic [31:0] temperature_i,
  input  wire logic [31:0] dew_point_i,
  input  wire logic        meas_valid_i,
  input  wire logic [31:0] error_flags_i,
  output logic [31:0]      filter_factor_o,
  output logic [15:0]      slave_address_o,
  output logic [15:0]      reply_delay_o,
  output logic [15:0]      baud_select_o,
  output logic [15:0]      baud_bps_o,
  output logic [15:0]      frame_format_select_o,
  output logic [15:0]      protocol_select_o,
  output logic             rtu_usable_o,
  output logic             restart_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] filter_q;
  logic [15:0] slave_addr_q;
  logic [15:0] baud_q;
  logic [15:0] frame_q;
  logic [15:0] delay_q;
  logic [15:0] proto_q;
  logic [31:0] hash_q;
  logic        restart_q;
  logic [63:0] read_d;
  logic        accept;
  logic        is_read;
  logic        is_write;
  logic        is_ident;
  logic        obj_ok;
  logic [7:0]  next_obj;

  assign accept   = link.req_valid && !link.rsp_valid;
  assign is_read  = link.req_func == FN_READ;
  assign is_write = link.req_func == FN_WRITE;
  assign is_ident = link.req_func == FN_IDENT && link.req_mei == MEI_IDENT;

  // unavailable measurements read as quiet nan
  function automatic logic [31:0] meas(input logic [31:0] v);
    return meas_valid_i ? v : QUIET_NAN;
  endfunction

  // one 16-bit register; low half at a, high half at a+1
  function automatic logic [15:0] half(input logic [31:0] v, input logic hi);
    return hi ? v[31:16] : v[15:0];
  endfunction

  function automatic logic [15:0] reg_read(input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;                                                              // gaps read zero
    case (a)
      RA_HUMIDITY, RA_HUMIDITY + 16'h1:       r = half(meas(humidity_i), a[0]);
      RA_TEMPERATURE, RA_TEMPERATURE + 16'h1: r = half(meas(temperature_i), a[0]);
      RA_DEW_POINT, RA_DEW_POINT + 16'h1:     r = half(meas(dew_point_i), a[0]);
      RA_FAULT:                               r = {15'h0000, error_flags_i == 32'h0};
      RA_ERROR:                               r = error_flags_i[15:0];
      RA_ERROR + 16'h1:                       r = error_flags_i[31:16];
      RA_HASH:                                r = hash_q[15:0];
      RA_HASH + 16'h1:                        r = hash_q[31:16];
      RA_FILTER, RA_FILTER + 16'h1:           r = half(filter_q, a[0]);
      RA_SLAVE_ADDR:                          r = slave_addr_q;
      RA_BAUD:                                r = baud_q;
      RA_FRAME:                               r = frame_q;
      RA_DELAY:                               r = delay_q;
      RA_PROTOCOL:                            r = proto_q;
      RA_RESTART:                             r = 16'h0000;
      RA_TEST_INT:                            r = TEST_INT_VAL;
      RA_TEST_FLOAT:                          r = TEST_FLOAT_VAL[15:0];
      RA_TEST_FLOAT + 16'h1:                  r = TEST_FLOAT_VAL[31:16];
      RA_TEST_TEXT:                           r = TEST_TEXT_VAL[63:48];
      RA_TEST_TEXT + 16'h1:                   r = TEST_TEXT_VAL[47:32];
      RA_TEST_TEXT + 16'h2:                   r = TEST_TEXT_VAL[31:16];
      RA_TEST_TEXT + 16'h3:                   r = TEST_TEXT_VAL[15:0];
      default:                                r = 16'h0000;
    endcase
    return r;
  endfunction

  // identity objects; each text holds at most seven characters and a zero
  function automatic logic [63:0] obj_text(input logic [7:0] id);
    case (id)
      8'h00:   return OBJ_MAKER;
      8'h01:   return OBJ_PART;
      8'h02:   return OBJ_REVISION;
      8'h03:   return OBJ_URL;
      8'h04:   return OBJ_NAME;
      8'h80:   return OBJ_SERIAL;
      8'h81:   return OBJ_CAL_DATE;
      8'h82:   return OBJ_CAL_NOTE;
      default: return 64'h0;
    endcase
  endfunction

  assign obj_ok = link.req_obj <= OBJ_LAST_STD ||
                  (link.req_obj >= OBJ_FIRST_EXT && link.req_obj <= OBJ_LAST_EXT);
  // stream access walks 0..4 then 128..130
  assign next_obj = (link.req_obj == OBJ_LAST_STD) ? OBJ_FIRST_EXT : link.req_obj + 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // read gather: register i of the request lands in bits 16*i+15..16*i
  always_comb begin
    read_d = 64'h0;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(link.req_count)) begin
        read_d[16*i +: 16] = reg_read(link.req_addr + 16'(i));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.rsp_valid    <= 1'b0;
      link.rsp_exc      <= 1'b0;
      link.rsp_data     <= 64'h0;
      link.rsp_next_obj <= 8'h00;
      link.rsp_more     <= 1'b0;
    end else begin
      link.rsp_valid <= accept;
      if (accept) begin
        link.rsp_exc      <= !(is_read || is_write || (is_ident && obj_ok)) ||
                             link.req_count == 3'd0 || link.req_count > 3'd4;
        link.rsp_data     <= is_ident ? obj_text(link.req_obj) : (is_read ? read_d : 64'h0);
        link.rsp_more     <= is_ident && link.req_stream && link.req_obj != OBJ_LAST_EXT;
        link.rsp_next_obj <= (is_ident && link.req_stream && link.req_obj != OBJ_LAST_EXT) ? next_obj : 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending settings; read-only addresses fall through untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_q     <= RST_FILTER;
      slave_addr_q <= RST_SLAVE_ADDR;
      baud_q       <= RST_BAUD;
      frame_q      <= RST_FRAME;
      delay_q      <= RST_DELAY;
      proto_q      <= RST_PROTOCOL;
      hash_q       <= 32'h0;
      restart_q    <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      // a count that draws an exception writes nothing
      if (accept && is_write && link.req_count inside {[3'd1:3'd4]}) begin
        for (int i = 0; i < 4; i++) begin
          if (i < int'(link.req_count)) begin
            case (link.req_addr + 16'(i))
              RA_FILTER:             filter_q[15:0]  <= link.req_wdata[16*i +: 16];
              RA_FILTER + 16'h1:     filter_q[31:16] <= link.req_wdata[16*i +: 16];
              RA_SLAVE_ADDR:         slave_addr_q    <= link.req_wdata[16*i +: 16];
              RA_BAUD:               baud_q          <= link.req_wdata[16*i +: 16];
              RA_FRAME:              frame_q         <= link.req_wdata[16*i +: 16];
              RA_DELAY:              delay_q         <= link.req_wdata[16*i +: 16];
              RA_PROTOCOL:           proto_q         <= link.req_wdata[16*i +: 16];
              RA_RESTART:            restart_q       <= link.req_wdata[16*i +: 16] == 16'h0001;
              default:               ;                                          // read-only kept
            endcase
          end
        end
        // any settings write scrambles the hash; a rotate-xor keeps it changing even on equal data
        hash_q <= {hash_q[30:0], hash_q[31]} ^ {link.req_addr, link.req_wdata[15:0]} ^
                  link.req_wdata[63:32] ^ 32'h9e3779b9;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active address, baud, framing and protocol load only on restart; filter and reply delay follow the pending values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_factor_o       <= RST_FILTER;
      slave_address_o       <= RST_SLAVE_ADDR;
      reply_delay_o         <= RST_DELAY;
      baud_select_o         <= RST_BAUD;
      baud_bps_o            <= mbp_baud_bps(RST_BAUD);
      frame_format_select_o <= RST_FRAME;
      protocol_select_o     <= RST_PROTOCOL;
      rtu_usable_o          <= 1'b1;
      restart_o             <= 1'b0;
    end else begin
      filter_factor_o <= filter_q;
      reply_delay_o   <= delay_q;
      restart_o       <= restart_q;
      if (restart_q) begin
        slave_address_o       <= slave_addr_q;
        baud_select_o         <= baud_q;
        baud_bps_o            <= mbp_baud_bps(baud_q);
        frame_format_select_o <= frame_q;
        protocol_select_o     <= proto_q;
        // codes 0..5 carry 8 data bits, 8..13 carry 7
        rtu_usable_o <= baud_q >= BAUD_MIN_RTU && baud_q <= BAUD_MAX_CODE &&
                        frame_q <= 16'h0005;
      end
    end
  end
endmodule // mbp_probe_regs

// File: verilog/mbp_master.sv
// link master: wishbone command registers driving requests to the probe bank
`timescale 1ns/1ps
module mbp_master
  import mbp_pkg::*;
#(
  parameter int unsigned WAIT_CYCLES = POWERUP_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  mbp_link_if.master       link,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o
);
  ////////////////////////////////////////////////////////////////////////////
  mbp_host_state_type state_q;
  logic [31:0] wait_q;
  logic [15:0] logical_q;
  logic [63:0] rdata_q;
  logic        done_q;
  logic        exc_q;
  logic        refused_q;
  logic        more_q;
  logic [7:0]  next_obj_q;
  logic        wr;
  logic        cmd_wr;
  logic [15:0] pdu_addr;
  logic [2:0]  cnt;
  logic        bad;

  assign wr       = cyc_i && stb_i && we_i && !ack_o;
  assign cmd_wr   = wr && adr_i == HR_CMD && sel_i[0];
  assign pdu_addr = logical_q - 16'h0001;
  assign cnt      = dat_i[10:8];
  // a pair start with count below two, a write starting on a pair's high half, or a single-register non-recommended framing write, is refused
  assign bad = (dat_i[7:0] != FN_IDENT &&
                ((mbp_pair_start(pdu_addr) && cnt < 3'd2) ||
                 mbp_pair_start(pdu_addr - 16'h0001) && cnt != 3'd0 && dat_i[7:0] == FN_WRITE)) ||
               (dat_i[7:0] == FN_WRITE && pdu_addr == RA_FRAME && cnt == 3'd1 &&
                !(link.req_wdata[15:0] inside {16'h0001, 16'h0002, 16'h0004}));

  ////////////////////////////////////////////////////////////////////////////
  // power-up hold-off and request sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= HS_WAIT;
      wait_q  <= 32'h0;
    end else begin
      case (state_q)
        HS_WAIT: begin
          wait_q <= wait_q + 32'h1;
          if (wait_q >= WAIT_CYCLES - 1) begin
            state_q <= HS_IDLE;
          end
        end
        HS_IDLE: if (cmd_wr && !bad) begin
          state_q <= HS_BUSY;
        end
        HS_BUSY: if (link.rsp_valid) begin
          state_q <= HS_IDLE;
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.req_valid  <= 1'b0;
      link.req_func   <= 8'h00;
      link.req_mei    <= 8'h00;
      link.req_count  <= 3'd0;
      link.req_stream <= 1'b0;
      link.req_addr   <= 16'h0;
    end else begin
      if (state_q == HS_IDLE && cmd_wr && !bad) begin
        link.req_valid  <= 1'b1;
        link.req_func   <= dat_i[7:0];
        link.req_mei    <= MEI_IDENT;
        link.req_count  <= cnt;
        link.req_stream <= dat_i[11];
        link.req_addr   <= pdu_addr;
      end else if (link.rsp_valid) begin
        link.req_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      logical_q      <= 16'h0001;
      link.req_obj   <= 8'h00;
      link.req_wdata <= 64'h0;
    end else if (wr && state_q != HS_BUSY) begin
      case (adr_i)
        HR_ADDR: begin
          logical_q    <= dat_i[15:0];
          link.req_obj <= dat_i[23:16];
        end
        HR_WDATA_LO: link.req_wdata[31:0]  <= dat_i;
        HR_WDATA_HI: link.req_wdata[63:32] <= dat_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q    <= 64'h0;
      done_q     <= 1'b0;
      exc_q      <= 1'b0;
      refused_q  <= 1'b0;
      more_q     <= 1'b0;
      next_obj_q <= 8'h00;
    end else begin
      if (cmd_wr) begin
        done_q    <= 1'b0;
        refused_q <= bad || state_q != HS_IDLE;
      end
      // a command landing with the answer is refused, but done must still be set
      if (state_q == HS_BUSY && link.rsp_valid) begin
        rdata_q    <= link.rsp_data;
        done_q     <= 1'b1;
        exc_q      <= link.rsp_exc;
        more_q     <= link.rsp_more;
        next_obj_q <= link.rsp_next_obj;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone answer: ack one cycle after strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      case (adr_i)
        HR_ADDR:     dat_o <= {8'h00, link.req_obj, logical_q};
        HR_WDATA_LO: dat_o <= link.req_wdata[31:0];
        HR_WDATA_HI: dat_o <= link.req_wdata[63:32];
        HR_RDATA_LO: dat_o <= rdata_q[31:0];
        HR_RDATA_HI: dat_o <= rdata_q[63:32];
        HR_STATUS:   dat_o <= {16'h0, next_obj_q, 2'b00, state_q == HS_WAIT, more_q, refused_q,
                               exc_q, done_q, state_q == HS_BUSY};
        default:     dat_o <= 32'h0;
      endcase
    end
  end
endmodule // mbp_master

// File: test/mbp_link_monitor.sv
// link checker: answer timing and fixed register contents
`timescale 1ns/1ps
module mbp_link_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        req_valid,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_addr,
  input wire logic [2:0]  req_count,
  input wire logic        rsp_valid,
  input wire logic        rsp_exc,
  input wire logic [63:0] rsp_data
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0]  fn_q;
  logic [15:0] ad_q;
  logic [2:0]  cn_q;
  logic        rd;
  // request is held until answered, so this copy is the taken request
  always_ff @(posedge clk_i) begin
    if (req_valid) begin
      fn_q <= req_func;
      ad_q <= req_addr;
      cn_q <= req_count;
    end
  end
  assign rd = rsp_valid && fn_q == 8'h03;
  ////////////////////////////////////////
  AST_RSP_NEXT: assert property (req_valid && !rsp_valid |=> rsp_valid) else $error("answer late");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid && !req_valid) else $error("answer too long");
  AST_REQ_HOLD: assert property (req_valid && !rsp_valid |=> $stable(req_addr) && $stable(req_func))
    else $error("request moved");
  AST_TEST_INT: assert property (rd && ad_q == 16'h1f00 |-> rsp_data[15:0] == 16'hcfc7)
    else $error("bad test integer");
  AST_TEST_FLOAT: assert property (rd && ad_q == 16'h1f01 && cn_q > 3'h1 |-> rsp_data[31:0] == 32'hc2f6e666)
    else $error("bad test float");
  AST_TEST_TEXT: assert property (rd && ad_q == 16'h1f03 && cn_q == 3'h4 |-> rsp_data == 64'h35002e3432332d31)
    else $error("bad test text");
  AST_WO_ZERO: assert property (rd && ad_q == 16'h0605 |-> rsp_data[15:0] == 16'h0000)
    else $error("write-only reads nonzero");
  AST_BAD_FUNC: assert property (rsp_valid && !(fn_q inside {8'h03, 8'h10, 8'h2b}) |-> rsp_exc)
    else $error("bad function accepted");
  AST_GAP_READ: assert property (rd && cn_q inside {[3'h1:3'h4]} |-> !rsp_exc) else $error("read refused");
  cover property (rsp_valid && rsp_exc);
  cover property (rd && ad_q == 16'h1f03);
  cover property (rsp_valid && fn_q == 8'h2b);
endmodule // mbp_link_monitor

// File: test/modbus_probe_register_map_test.sv
// bench: wishbone commands through the link master into the probe bank
`timescale 1ns/1ps
module modbus_probe_register_map_test;
  import mbp_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, meas = 1, ack_o, rtu, restart;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0, hum = 0, dat_o, s, stat, h0, fv, filt;
  logic [63:0] rd;
  logic [15:0] bsel, bbps, fsel, psel, code, fr;
  int          failures = 0, check_count = 0, cycles = 0, seed = 32'h2ec5, restarts = 0;
  mbp_link_if link ();
  mbp_probe_regs i_mbp_probe_regs (.clk_i, .rst_i, .link(link.device), .humidity_i(hum), .temperature_i(hum),
    .dew_point_i(hum), .meas_valid_i(meas), .error_flags_i(hum), .filter_factor_o(filt), .slave_address_o(),
    .reply_delay_o(), .baud_select_o(bsel), .baud_bps_o(bbps), .frame_format_select_o(fsel),
    .protocol_select_o(psel), .rtu_usable_o(rtu), .restart_o(restart));
  mbp_master #(.WAIT_CYCLES(10)) i_mbp_master (.clk_i, .rst_i, .link(link.master), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o, .ack_o);
  mbp_link_monitor i_mbp_link_monitor (.clk_i, .rst_i, .req_valid(link.req_valid), .req_func(link.req_func),
    .req_addr(link.req_addr), .req_count(link.req_count), .rsp_valid(link.rsp_valid), .rsp_exc(link.rsp_exc),
    .rsp_data(link.rsp_data));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (restart === 1'b1) restarts++;
  always @(posedge clk_i) if (++cycles == 5000) begin
    failures++;
    test_done();
  end
  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    s = dat_o;
    cyc <= 0; stb <= 0;
    @(posedge clk_i);
  endtask
  // address goes in as the one-based logical number
  task automatic op(input logic [7:0] f, input logic [2:0] c, input logic [15:0] ra, input logic [7:0] ob,
                    input logic [63:0] wd, input logic st = 0);
    wb(1, HR_ADDR, {8'h00, ob, ra + 16'h0001});
    wb(1, HR_WDATA_LO, wd[31:0]);
    wb(1, HR_WDATA_HI, wd[63:32]);
    wb(1, HR_CMD, {20'h00000, st, c, f});
    s = 0;
    for (int i = 0; i < 30 && !(s[1] === 1'b1 && s[0] === 1'b0); i++) wb(0, HR_STATUS, 0);
    stat = s;
    wb(0, HR_RDATA_LO, 0);
    rd[31:0] = s;
    wb(0, HR_RDATA_HI, 0);
    rd[63:32] = s;
  endtask
  function automatic logic [15:0] bps(input logic [15:0] c);
    return (c == 16'h0008) ? 16'd57600 : 16'(300 << c);
  endfunction
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, HR_STATUS, 0);
    chk("waiting", s[5], 1);
    wb(1, HR_CMD, 32'h00000203);
    wb(0, HR_STATUS, 0);
    chk("early", s[3], 1);
    s = 32'h20;
    for (int i = 0; i < 40 && s[5] !== 1'b0; i++) wb(0, HR_STATUS, 0);
    op(FN_READ, 1, 16'h1f00, 0, 0);
    chk("int", rd[15:0], 16'hcfc7);
    op(FN_READ, 2, 16'h1f01, 0, 0);
    chk("float", rd[31:0], 32'hc2f6e666);
    op(FN_READ, 4, 16'h1f03, 0, 0);
    chk("text", rd, 64'h35002e3432332d31);
    op(FN_WRITE, 1, 16'h1f00, 0, 64'h1234);
    op(FN_READ, 1, 16'h1f00, 0, 0);
    chk("ro", rd[15:0], 16'hcfc7);
    op(FN_READ, 2, 16'h0100, 0, 0);
    chk("gap", rd[31:0], 0);
    op(FN_READ, 1, RA_FAULT, 0, 0);
    chk("fault", rd[15:0], 1);
    hum <= $random(seed);
    meas <= 0;
    op(FN_READ, 2, RA_HUMIDITY, 0, 0);
    chk("nan", rd[31:0], 32'h7fc00000);
    meas <= 1;
    op(FN_READ, 2, RA_HUMIDITY, 0, 0);
    chk("hum", rd[31:0], hum);
    op(FN_READ, 2, RA_ERROR, 0, 0);
    chk("errors", rd[31:0], hum);
    op(FN_READ, 2, RA_HASH, 0, 0);
    h0 = rd[31:0];
    fv = $random(seed);
    op(FN_WRITE, 2, RA_FILTER, 0, {32'h0, fv});
    chk("filter", filt, fv);
    op(FN_READ, 2, RA_HASH, 0, 0);
    chk("hash", rd[31:0] !== h0, 1);
    op(FN_READ, 1, RA_TEST_FLOAT, 0, 0);
    chk("split", stat[3], 1);
    op(FN_WRITE, 1, RA_FRAME, 0, 64'h3);
    chk("framing", stat[3], 1);
    code = $unsigned($random(seed)) % 9;
    fr = $unsigned($random(seed)) % 12;
    fr = fr < 6 ? fr : fr + 16'h0002;
    op(FN_WRITE, 4, RA_BAUD, 0, {16'h0006, 16'h0000, fr, code});
    chk("held", bsel, RST_BAUD);
    op(FN_WRITE, 1, RA_RESTART, 0, 1);
    chk("baud", bsel, code);
    chk("restart", restarts, 1);
    chk("bps", bbps, bps(code));
    chk("frame", fsel, fr);
    chk("proto", psel, 16'h0006);
    chk("rtu", rtu, code >= 5 && fr < 8);
    op(FN_READ, 1, RA_RESTART, 0, 0);
    chk("wo", rd[15:0], 0);
    op(FN_IDENT, 1, 0, 8'h80, 0);
    chk("obj", stat[2], 0);
    op(FN_IDENT, 1, 0, 8'h05, 0);
    chk("badobj", stat[2], 1);
    op(FN_IDENT, 1, 0, 8'h00, 0, 1);
    chk("more", stat[4], 1);
    chk("next", stat[15:8], 8'h01);
    op(FN_IDENT, 1, 0, 8'h04, 0, 1);
    chk("wrap", stat[15:8], 8'h80);
    op(8'h05, 1, RA_FAULT, 0, 0);
    chk("badfn", stat[2], 1);
    test_done();
  end
endmodule // modbus_probe_register_map_test
